/* File: rtl/flash_prot_regs.vh */
// Register offsets, field positions, key and op codes, and timing counts of the flash protection block
`ifndef FLASH_PROT_REGS_VH
`define FLASH_PROT_REGS_VH
`define FP_CMD_OFS 8'h00
`define FP_LOCK_OFS 8'h04
`define FP_GPNVM_OFS 8'h08
`define FP_SEC_OFS 8'h0c
`define FP_STAT_OFS 8'h10
`define FP_MASK_OFS 8'h14
`define FP_CALIB_OFS 8'h18
`define FP_CMD_POS 8
`define FP_PAGE_POS 12
`define FP_KEY_POS 24
`define FP_KEY_VAL 8'h5a
`define FP_OP_PROG 4'h1
`define FP_OP_SLOCK 4'h2
`define FP_OP_CLOCK 4'h4
`define FP_OP_ERASE_PAGE 4'h6
`define FP_OP_ERASE_ALL 4'h8
`define FP_OP_SGPB 4'hb
`define FP_OP_CGPB 4'hd
`define FP_OP_SSEC 4'hf
`define FP_ST_DONE 0
`define FP_ST_LOCKE 1
`define FP_ST_CMDE 2
`define FP_ST_PORTE 3
`define FP_GP_BOD_EN 0
`define FP_GP_BOD_RST 1
`define FP_GP_BOOT 2
`define FP_PAGES_PER_REGION 64
`define FP_WIPE_MIN_MS 220
`define FP_CLK_MHZ 100
`endif

/* File: rtl/flash_protection_nvm_bits.v */
// Flash lock, security and general-purpose NVM bit logic with an AXI4-Lite register slave
`timescale 1ns/1ps
`include "flash_prot_regs.vh"

module flash_protection_nvm_bits #(
  parameter NUM_REGIONS = 16,
  parameter PAGE_W = 10,
  parameter WIPE_CYCLES = `FP_WIPE_MIN_MS * 1000 * `FP_CLK_MHZ
) (
  input wire ref_clk_i,
  input wire srst_i,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire [NUM_REGIONS-1:0] nvm_lock_i,
  input wire nvm_sec_i,
  input wire [2:0] nvm_gpnvm_i,
  input wire [7:0] nvm_calib_i,
  input wire wipe_pin_i,
  input wire test_mode_pin_i,
  input wire port_a_line_zero_i,
  input wire port_a_line_one_i,
  input wire dbg_req_i,
  output wire dbg_grant_o,
  input wire fpp_req_i,
  input wire [3:0] fpp_op_i,
  input wire [PAGE_W-1:0] fpp_page_i,
  output reg fpp_done_o,
  output reg fpp_err_o,
  output wire fpp_enable_o,
  output reg flash_prog_o,
  output reg flash_erase_page_o,
  output reg flash_erase_all_o,
  output reg [PAGE_W-1:0] flash_page_o,
  output wire [NUM_REGIONS-1:0] lock_o,
  output wire sec_o,
  output wire bod_en_o,
  output wire bod_rst_en_o,
  output wire boot_from_flash_o,
  output wire rom_at_zero_o,
  output wire [7:0] calib_o,
  output wire irq_o
);

  localparam RW = (NUM_REGIONS > 1) ? $clog2(NUM_REGIONS) : 1;
  localparam CW = $clog2(WIPE_CYCLES + 1);

  // Region of a page: page number divided by the pages per region
  function [RW-1:0] region_of;
    input [PAGE_W-1:0] pg;
    begin
      region_of = pg[RW+5:6];
    end
  endfunction

  // Page-touching operation check, shared by the bus and fast port paths
  function touches_page;
    input [3:0] op;
    begin
      touches_page = (op == `FP_OP_PROG) || (op == `FP_OP_ERASE_PAGE);
    end
  endfunction

  reg [NUM_REGIONS-1:0] lock_q;
  reg sec_q;
  reg [2:0] gp_q;
  reg [7:0] calib_q;
  reg [3:0] stat_q;
  reg [3:0] mask_q;
  reg [CW-1:0] wipe_cnt_q;
  reg wiped_q;
  reg aw_q;
  reg w_q;
  reg [7:0] awaddr_q;
  reg [31:0] wdata_q;
  reg [3:0] wstrb_q;

  wire wipe_now = wipe_pin_i && (wipe_cnt_q == WIPE_CYCLES[CW-1:0]);
  wire fpp_mode = test_mode_pin_i && port_a_line_zero_i && port_a_line_one_i;
  assign fpp_enable_o = fpp_mode;
  assign dbg_grant_o = dbg_req_i && !sec_q;

  assign s_axi_awready = !aw_q && !s_axi_bvalid;
  assign s_axi_wready = !w_q && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  wire wr_go = aw_q && w_q && !s_axi_bvalid;
  wire [3:0] cmd_op = wdata_q[`FP_CMD_POS+3:`FP_CMD_POS];
  // Page field sits clear of the op field so every region can be addressed
  wire [PAGE_W-1:0] cmd_page = wdata_q[`FP_PAGE_POS+PAGE_W-1:`FP_PAGE_POS];
  wire cmd_ok = wr_go && (awaddr_q == `FP_CMD_OFS) && wstrb_q[3] && wstrb_q[1]
                && (wdata_q[31:`FP_KEY_POS] == `FP_KEY_VAL);
  wire fpp_go = fpp_req_i && fpp_mode;
  wire fpp_refused = fpp_go && sec_q;
  wire fpp_ok = fpp_go && !sec_q;

  // Bus command takes priority over the fast port in the same cycle
  wire act = cmd_ok || fpp_ok;
  wire [3:0] op = cmd_ok ? cmd_op : fpp_op_i;
  wire [PAGE_W-1:0] page = cmd_ok ? cmd_page : fpp_page_i;
  wire [RW-1:0] rgn = region_of(page);
  wire [1:0] gsel = page[1:0];
  wire op_locked = act && touches_page(op) && lock_q[rgn];
  wire op_valid = (op == `FP_OP_PROG) || (op == `FP_OP_SLOCK) || (op == `FP_OP_CLOCK) ||
                  (op == `FP_OP_ERASE_PAGE) || (op == `FP_OP_ERASE_ALL) ||
                  (op == `FP_OP_SSEC) || ((op == `FP_OP_SGPB || op == `FP_OP_CGPB) && gsel != 2'd3);
  wire op_bad = act && !op_valid;
  wire op_run = act && op_valid && !op_locked;

  always @(posedge ref_clk_i) begin
    if (srst_i) begin
      wipe_cnt_q <= {CW{1'b0}};
      wiped_q <= 1'b0;
    end else begin
      // Counting the hold filters glitches; a short pulse never wipes
      if (!wipe_pin_i)
        wipe_cnt_q <= {CW{1'b0}};
      else if (wipe_cnt_q != WIPE_CYCLES[CW-1:0])
        wipe_cnt_q <= wipe_cnt_q + 1'b1;
      if (wipe_now)
        wiped_q <= 1'b1;
      else if (op_run && op == `FP_OP_ERASE_ALL)
        wiped_q <= 1'b0;
    end
  end

  reg load_q;
  always @(posedge ref_clk_i) begin
    if (srst_i) begin
      load_q <= 1'b1;
      lock_q <= {NUM_REGIONS{1'b0}};
      sec_q <= 1'b1;
      gp_q <= 3'h0;
      calib_q <= 8'h00;
    end else if (load_q) begin
      // First cycle after reset copies the stored NVM image
      load_q <= 1'b0;
      lock_q <= nvm_lock_i;
      sec_q <= nvm_sec_i;
      gp_q <= nvm_gpnvm_i;
      calib_q <= nvm_calib_i;
    end else if (wipe_now) begin
      lock_q <= {NUM_REGIONS{1'b0}};
      gp_q <= 3'h0;
    end else if (op_run) begin
      case (op)
        `FP_OP_SLOCK: lock_q[rgn] <= 1'b1;
        `FP_OP_CLOCK: lock_q[rgn] <= 1'b0;
        `FP_OP_SGPB: gp_q[gsel] <= 1'b1;
        `FP_OP_CGPB: gp_q[gsel] <= 1'b0;
        `FP_OP_SSEC: sec_q <= 1'b1;
        `FP_OP_ERASE_ALL: if (wiped_q) sec_q <= 1'b0;
        default: ;
      endcase
    end
  end

  always @(posedge ref_clk_i) begin
    if (srst_i) begin
      flash_prog_o <= 1'b0;
      flash_erase_page_o <= 1'b0;
      flash_erase_all_o <= 1'b0;
      flash_page_o <= {PAGE_W{1'b0}};
      fpp_done_o <= 1'b0;
      fpp_err_o <= 1'b0;
    end else begin
      // A locked target never reaches the program or page-erase strobes; erase-all ignores the lock bits
      flash_prog_o <= op_run && op == `FP_OP_PROG;
      flash_erase_page_o <= op_run && op == `FP_OP_ERASE_PAGE;
      flash_erase_all_o <= op_run && op == `FP_OP_ERASE_ALL;
      flash_page_o <= act ? page : flash_page_o;
      fpp_done_o <= fpp_go && !cmd_ok;
      fpp_err_o <= fpp_refused || (fpp_ok && !cmd_ok && (op_locked || op_bad));
    end
  end

  // Sticky status: set wins over the write-one-to-clear
  wire [3:0] ev = {fpp_refused || (dbg_req_i && sec_q), op_bad, op_locked, op_run};
  wire [3:0] w1c = (wr_go && awaddr_q == `FP_STAT_OFS && wstrb_q[0]) ? wdata_q[3:0] : 4'h0;
  always @(posedge ref_clk_i) begin
    if (srst_i) begin
      stat_q <= 4'h0;
      mask_q <= 4'h0;
    end else begin
      stat_q <= (stat_q & ~w1c) | ev;
      if (wr_go && awaddr_q == `FP_MASK_OFS && wstrb_q[0])
        mask_q <= wdata_q[3:0];
    end
  end
  assign irq_o = |(stat_q & mask_q);

  always @(posedge ref_clk_i) begin
    if (srst_i) begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_q <= 1'b1;
        awaddr_q <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_q <= 1'b0;
        w_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (awaddr_q == `FP_CMD_OFS || awaddr_q == `FP_STAT_OFS ||
                        awaddr_q == `FP_MASK_OFS) ? 2'b00 : 2'b10;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  reg [31:0] rd_d;
  reg rd_err;
  always @* begin
    rd_d = 32'h00000000;
    rd_err = 1'b0;
    case ({s_axi_araddr[7:2], 2'b00})
      `FP_LOCK_OFS: rd_d[NUM_REGIONS-1:0] = lock_q;
      `FP_GPNVM_OFS: rd_d[2:0] = gp_q;
      `FP_SEC_OFS: rd_d[0] = sec_q;
      `FP_STAT_OFS: rd_d[3:0] = stat_q;
      `FP_MASK_OFS: rd_d[3:0] = mask_q;
      `FP_CALIB_OFS: rd_d[7:0] = calib_q;
      `FP_CMD_OFS: rd_d = 32'h00000000;
      default: rd_err = 1'b1;
    endcase
  end

  always @(posedge ref_clk_i) begin
    if (srst_i) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= 2'b00;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_d;
      s_axi_rresp <= rd_err ? 2'b10 : 2'b00;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  assign lock_o = lock_q;
  assign sec_o = sec_q;
  assign bod_en_o = gp_q[`FP_GP_BOD_EN];
  assign bod_rst_en_o = gp_q[`FP_GP_BOD_RST];
  assign boot_from_flash_o = gp_q[`FP_GP_BOOT];
  assign rom_at_zero_o = !gp_q[`FP_GP_BOOT];
  assign calib_o = calib_q;

endmodule // flash_protection_nvm_bits

/* File: testbench/flash_prot_checker.sv */
// Port-level assertions for the flash protection block
`timescale 1ns/1ps
module flash_prot_checker #(
  parameter NUM_REGIONS = 16,
  parameter PAGE_W = 10,
  parameter WIPE_CYCLES = 8
) (
  input wire ref_clk_i,
  input wire srst_i,
  input wire s_axi_wvalid,
  input wire wipe_pin_i,
  input wire test_mode_pin_i,
  input wire port_a_line_zero_i,
  input wire port_a_line_one_i,
  input wire dbg_req_i,
  input wire dbg_grant_o,
  input wire fpp_req_i,
  input wire [3:0] fpp_op_i,
  input wire [PAGE_W-1:0] fpp_page_i,
  input wire fpp_err_o,
  input wire fpp_enable_o,
  input wire flash_prog_o,
  input wire flash_erase_page_o,
  input wire [PAGE_W-1:0] flash_page_o,
  input wire [NUM_REGIONS-1:0] lock_o,
  input wire sec_o,
  input wire bod_en_o,
  input wire bod_rst_en_o,
  input wire boot_from_flash_o,
  input wire rom_at_zero_o,
  input wire [7:0] calib_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (srst_i);
  // A bus command in the same cycle wins; only program and page-erase requests with s_axi_wvalid low are taken
  sequence fpp_take;
    fpp_req_i && fpp_enable_o && !s_axi_wvalid && fpp_op_i inside {4'h1, 4'h6};
  endsequence
  // High for the scaled wipe count of 8 cycles, then high again 4 cycles later
  sequence wipe_held;
    wipe_pin_i [*8] ##4 wipe_pin_i;
  endsequence
  AST_DBG_BLOCK: assert property (dbg_req_i && sec_o |-> !dbg_grant_o)
    else $error("debug access granted while secured");
  AST_FPP_ENABLE: assert property (fpp_enable_o == (test_mode_pin_i && port_a_line_zero_i && port_a_line_one_i))
    else $error("fast port enable does not follow pins");
  AST_BOOT_MAP: assert property (rom_at_zero_o != boot_from_flash_o)
    else $error("boot source and rom mapping disagree");
  AST_FPP_LOCKED: assert property (fpp_take ##0 lock_o[fpp_page_i[PAGE_W-1:6]] |=> fpp_err_o && !flash_prog_o && !flash_erase_page_o)
    else $error("locked region command not aborted");
  AST_FPP_SECURE: assert property (fpp_take ##0 sec_o |=> fpp_err_o && !flash_prog_o && !flash_erase_page_o)
    else $error("fast port command passed while secured");
  AST_NO_LOCKED_WRITE: assert property (flash_prog_o || flash_erase_page_o |-> !lock_o[flash_page_o[PAGE_W-1:6]])
    else $error("flash touched in a locked region");
  AST_CALIB_FIXED: assert property (!$past(srst_i) && !$past(srst_i, 2) |-> $stable(calib_o))
    else $error("calibration bits changed");
  AST_WIPE_CLEAR: assert property (wipe_held |-> lock_o == '0 && !bod_en_o && !bod_rst_en_o && !boot_from_flash_o)
    else $error("wipe left lock or general bits set");
endmodule // flash_prot_checker

bind flash_protection_nvm_bits flash_prot_checker #(.NUM_REGIONS(NUM_REGIONS), .PAGE_W(PAGE_W),
  .WIPE_CYCLES(WIPE_CYCLES)) u_chk (.*);

/* File: testbench/fast_port_model.sv */
// Fast programming port model on the block's far side
`timescale 1ns/1ps
module fast_port_model (
  input wire ref_clk_i,
  input wire fpp_done_i,
  input wire fpp_err_i,
  output logic fpp_req_o = 1'b0,
  output logic [3:0] fpp_op_o = 4'h0,
  output logic [9:0] fpp_page_o = 10'h3ff,
  output logic test_mode_o = 1'b1,
  output logic line_zero_o = 1'b1,
  output logic line_one_o = 1'b1
);
  // One-cycle request; released lines are scrambled so stale values are never trusted
  task issue(input logic [3:0] op, input logic [9:0] pg, output logic [1:0] res);
    @(posedge ref_clk_i);
    fpp_req_o <= 1'b1;
    fpp_op_o <= op;
    fpp_page_o <= pg;
    @(posedge ref_clk_i);
    fpp_req_o <= 1'b0;
    fpp_op_o <= ~op;
    fpp_page_o <= ~pg;
    @(posedge ref_clk_i);
    res = {fpp_err_i, fpp_done_i};
  endtask
endmodule // fast_port_model

/* File: testbench/flash_protection_nvm_bits_tb.sv */
// Self-checking bench for the flash protection block
`timescale 1ns/1ps
`include "flash_prot_regs.vh"
module flash_protection_nvm_bits_tb;
  logic ref_clk_i = 1'b0, srst_i = 1'b1, wipe_pin_i = 1'b0, dbg_req_i = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, nvm_calib_i = 8'ha5;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb = 4'hf, fpp_op_i;
  logic [15:0] nvm_lock_i = 16'h8000, lock_o;
  logic nvm_sec_i = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, dbg_grant_o;
  logic [2:0] nvm_gpnvm_i = 3'h0;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp, fr;
  logic test_mode_pin_i, port_a_line_zero_i, port_a_line_one_i, fpp_req_i, fpp_done_o, fpp_err_o, fpp_enable_o;
  logic flash_prog_o, flash_erase_page_o, flash_erase_all_o, sec_o, bod_en_o, bod_rst_en_o, irq_o;
  logic boot_from_flash_o, rom_at_zero_o;
  logic [9:0] fpp_page_i, flash_page_o;
  logic [7:0] calib_o;
  int failures = 0, n_compared = 0;
  // Command word, readback offset, expected readback
  logic [71:0] rows [7] = '{{32'h5a005200, 8'h04, 32'h8001}, {32'h5a082200, 8'h04, 32'h8005},
    {32'h5a005400, 8'h04, 32'h8004}, {32'h5a000b00, 8'h08, 32'h1}, {32'h5a001b00, 8'h08, 32'h3},
    {32'h5a002b00, 8'h08, 32'h7}, {32'h5a001d00, 8'h08, 32'h5}};
  // Wipe count shortened from 220 ms to 8 cycles
  flash_protection_nvm_bits #(.NUM_REGIONS(16), .PAGE_W(10), .WIPE_CYCLES(8)) dut (.*);
  fast_port_model u_fp (.ref_clk_i(ref_clk_i), .fpp_done_i(fpp_done_o), .fpp_err_i(fpp_err_o), .fpp_req_o(fpp_req_i),
    .fpp_op_o(fpp_op_i), .fpp_page_o(fpp_page_i), .test_mode_o(test_mode_pin_i), .line_zero_o(port_a_line_zero_i),
    .line_one_o(port_a_line_one_i));
  initial forever #5 ref_clk_i = ~ref_clk_i;
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task axw(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge ref_clk_i);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task axr(input logic [7:0] a);
    @(posedge ref_clk_i);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge ref_clk_i);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task end_of_test;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge ref_clk_i);
    srst_i <= 1'b0;
    axr(`FP_LOCK_OFS);
    chk(rd, 32'h8000);
    axr(`FP_CALIB_OFS);
    chk(rd, 32'ha5);
    $display("test reset done");
    for (int i = 0; i < 7; i++) begin
      axw(`FP_CMD_OFS, rows[i][71:40]);
      axr(rows[i][39:32]);
      chk(rd, rows[i][31:0]);
    end
    chk({boot_from_flash_o, bod_rst_en_o, bod_en_o}, 32'h5);
    $display("test commands done");
    axw(`FP_MASK_OFS, 32'h0);
    axw(`FP_CMD_OFS, 32'h5a082100);
    axr(`FP_STAT_OFS);
    chk(rd & 32'h2, 32'h2);
    chk(irq_o, 32'h0);
    axw(`FP_MASK_OFS, 32'h2);
    @(posedge ref_clk_i);
    chk(irq_o, 32'h1);
    axw(`FP_STAT_OFS, 32'h2);
    @(posedge ref_clk_i);
    chk(irq_o, 32'h0);
    $display("test abort done");
    u_fp.issue(4'h1, 10'd5, fr);
    chk(fr, 32'h1);
    u_fp.issue(4'h6, 10'd130, fr);
    chk(fr, 32'h3);
    $display("test fast port done");
    axw(`FP_CMD_OFS, 32'h5a000f00);
    dbg_req_i <= 1'b1;
    @(posedge ref_clk_i);
    chk({sec_o, dbg_grant_o}, 32'h2);
    u_fp.issue(4'h1, 10'd5, fr);
    chk(fr, 32'h3);
    axw(`FP_SEC_OFS, 32'h0);
    chk({rsp, sec_o}, 32'h5);
    axw(`FP_CMD_OFS, 32'h5a000800);
    chk(sec_o, 32'h1);
    wipe_pin_i <= 1'b1;
    repeat (16) @(posedge ref_clk_i);
    wipe_pin_i <= 1'b0;
    chk({lock_o, boot_from_flash_o, bod_en_o, bod_rst_en_o, sec_o}, 32'h1);
    chk(calib_o, 32'ha5);
    axw(`FP_CMD_OFS, 32'h5a000800);
    @(posedge ref_clk_i);
    chk({sec_o, dbg_grant_o}, 32'h1);
    $display("test security done");
    axr(8'h1c);
    chk({rsp, rd[29:0]}, 32'h80000000);
    $display("test unmapped done");
    end_of_test();
  end
  initial begin
    repeat (5000) @(posedge ref_clk_i);
    failures++;
    $display("watchdog expired");
    end_of_test();
  end
endmodule // flash_protection_nvm_bits_tb
